// File: hdl/dpl23_pkg.sv
// dpl23_pkg: constants for the downstream port L2/L3 power sequencer
// assumes a 10 MHz sys_clk and a plain strobe register port
`default_nettype none
package dpl23_pkg;
  localparam logic [11:0] ADDR_PWR_CTRL = 12'h09C;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h0A0;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h0A4;
  localparam logic [11:0] ADDR_LINK_PM  = 12'h0A8;
  // control register fields (offset 9C)
  localparam int BIT_ENTER_REQ = 0;
  localparam int BIT_PWR_OFF   = 1;
  localparam int BIT_RECOVER   = 2;
  localparam int BIT_IS_L23    = 8;
  localparam int BIT_PWR_IS_OFF = 9;
  localparam int BIT_BUSY      = 10;
  localparam int BIT_DEV_RST   = 11;
  // interrupt bits
  localparam int IRQ_ACK     = 0;
  localparam int IRQ_OFF     = 1;
  localparam int IRQ_UP      = 2;
  localparam int IRQ_W       = 3;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  // timing
  localparam int CLK_HZ          = 10_000_000;
  localparam int PWR_SETTLE_US   = 100;
  localparam int PWR_SETTLE_CYC  = PWR_SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int DEV_RST_US      = 100;
  localparam int DEV_RST_CYC     = DEV_RST_US * (CLK_HZ / 1_000_000);
  localparam int L23_WAIT_US     = 10;
  localparam int L23_WAIT_CYC    = L23_WAIT_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W           = 16;
  // link power states
  typedef enum logic [2:0] {
    DPL23_LS_L0   = 3'h0,
    DPL23_LS_L0S  = 3'h1,
    DPL23_LS_L1   = 3'h3,
    DPL23_LS_L23R = 3'h2,
    DPL23_LS_L3   = 3'h6
  } dpl23_link_e;
  // sequencer states, gray on each step from ON to RESET, not on RESET back to ON
  typedef enum logic [2:0] {
    DPL23_ST_ON      = 3'h0,
    DPL23_ST_WAITACK = 3'h1,
    DPL23_ST_L23     = 3'h3,
    DPL23_ST_OFF     = 3'h2,
    DPL23_ST_PWRUP   = 3'h6,
    DPL23_ST_RESET   = 3'h7
  } dpl23_state_e;
endpackage : dpl23_pkg
`default_nettype wire

// File: hdl/dpl23_power_ctrl.sv
// dpl23_power_ctrl: per downstream port L2/L3 entry, power cut, recovery
// assumes link layer handshakes and external power module are outside
// Functional notes
// - the port sends a turn-off message to its own device alone.
// - after L2/L3 and a software command, the device's power is cut.
// - on software recovery power comes back first, then a device reset.
// - the downstream port holds the control register at offset 9Ch.
// - while the fundamental reset is low every function stays in reset.
// - link states L0, L0s, L1, L2/L3 ready and L3 with ASPM are supported.
`default_nettype none
module dpl23_power_ctrl
  import dpl23_pkg::*;
#(
  parameter int SETTLE_CYC = PWR_SETTLE_CYC,
  parameter int RESET_CYC  = DEV_RST_CYC,
  parameter int IDLE_CYC   = L23_WAIT_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             turnoff_msg,
  input  wire logic        turnoff_ack,
  input  wire logic        link_idle,
  output logic             pwr_en,
  output logic             dev_rst_n,
  output logic             aspm_en,
  output logic      [2:0]  link_state,
  output logic             irq
);
  // link_idle is a pin: three stages, change counted when 2 and 3 agree
  logic [2:0] idle_sync_q;
  logic       idle_q, idle_d;
  dpl23_state_e st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d;
  logic aspm_q, aspm_d;
  dpl23_link_e ls_q, ls_d;
  logic [31:0] rdata_d;
  logic msg_d, pwr_d, rst_d, irq_d;
  logic [IRQ_W-1:0] ev;
  logic wr_ctrl, ack_ev;

  assign wr_ctrl = reg_wr && reg_addr == ADDR_PWR_CTRL;
  assign ack_ev  = st_q == DPL23_ST_WAITACK && turnoff_ack;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    ev     = '0;
    idle_d = (idle_sync_q[1] == idle_sync_q[2]) ? idle_sync_q[2] : idle_q;
    unique case (st_q)
      DPL23_ST_ON: begin
        if (wr_ctrl && reg_wdata[BIT_ENTER_REQ])
          st_d = DPL23_ST_WAITACK;
      end
      DPL23_ST_WAITACK: begin
        cnt_d = '0;
        if (ack_ev) begin
          st_d = DPL23_ST_L23;
          ev[IRQ_ACK] = 1'b1;
        end
      end
      DPL23_ST_L23: begin
        // link must stay electrically idle a while before power may go
        if (!idle_q)
          cnt_d = '0;
        else if (cnt_q < CNT_W'(IDLE_CYC))
          cnt_d = cnt_q + 1'b1;
        if (wr_ctrl && reg_wdata[BIT_PWR_OFF] &&
            cnt_q >= CNT_W'(IDLE_CYC)) begin
          st_d = DPL23_ST_OFF;
          ev[IRQ_OFF] = 1'b1;
        end
      end
      DPL23_ST_OFF: begin
        cnt_d = '0;
        if (wr_ctrl && reg_wdata[BIT_RECOVER])
          st_d = DPL23_ST_PWRUP;
      end
      DPL23_ST_PWRUP: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q >= CNT_W'(SETTLE_CYC - 1)) begin
          cnt_d = '0;
          st_d  = DPL23_ST_RESET;
        end
      end
      DPL23_ST_RESET: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q >= CNT_W'(RESET_CYC - 1)) begin
          cnt_d = '0;
          st_d  = DPL23_ST_ON;
          ev[IRQ_UP] = 1'b1;
        end
      end
      default: st_d = DPL23_ST_ON;
    endcase
  end

  always_comb begin
    msg_d  = st_d == DPL23_ST_WAITACK;
    pwr_d  = !(st_d == DPL23_ST_OFF);
    rst_d  = !(st_d == DPL23_ST_RESET || st_d == DPL23_ST_OFF ||
               st_d == DPL23_ST_PWRUP);
    aspm_d = aspm_q;
    mask_d = mask_q;
    if (reg_wr && reg_addr == ADDR_LINK_PM)
      aspm_d = reg_wdata[0];
    if (reg_wr && reg_addr == ADDR_IRQ_MASK)
      mask_d = reg_wdata[IRQ_W-1:0];
    // set wins over read clear
    stat_d = stat_q;
    if (reg_rd && reg_addr == ADDR_IRQ_STAT)
      stat_d = '0;
    stat_d = stat_d | ev;
    irq_d  = |(stat_d & mask_d);
    unique case (st_d)
      DPL23_ST_L23:  ls_d = DPL23_LS_L23R;
      DPL23_ST_OFF:  ls_d = DPL23_LS_L3;
      DPL23_ST_PWRUP, DPL23_ST_RESET: ls_d = DPL23_LS_L3;
      DPL23_ST_WAITACK: ls_d = DPL23_LS_L0;
      default: ls_d = aspm_d ? (idle_q ? DPL23_LS_L1 : DPL23_LS_L0S)
                             : DPL23_LS_L0;
    endcase
    rdata_d = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_PWR_CTRL: begin
          rdata_d[BIT_IS_L23]     = st_q == DPL23_ST_L23 ||
                                    st_q == DPL23_ST_OFF;
          rdata_d[BIT_PWR_IS_OFF] = !pwr_en;
          rdata_d[BIT_BUSY]       = st_q == DPL23_ST_WAITACK ||
                                    st_q == DPL23_ST_PWRUP;
          rdata_d[BIT_DEV_RST]    = !dev_rst_n;
        end
        ADDR_IRQ_STAT: rdata_d[IRQ_W-1:0] = stat_q;
        ADDR_IRQ_MASK: rdata_d[IRQ_W-1:0] = mask_q;
        ADDR_LINK_PM:  rdata_d[0] = aspm_q;
        default:       rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    idle_sync_q <= {idle_sync_q[1:0], link_idle};
    if (!reset_n) begin
      st_q        <= DPL23_ST_ON;
      cnt_q       <= '0;
      stat_q      <= '0;
      mask_q      <= IRQ_MASK_RST;
      aspm_q      <= 1'b0;
      ls_q        <= DPL23_LS_L0;
      idle_q      <= 1'b0;
      reg_rdata   <= '0;
      turnoff_msg <= 1'b0;
      pwr_en      <= 1'b1;
      dev_rst_n   <= 1'b0;
      irq         <= 1'b0;
    end else begin
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      stat_q      <= stat_d;
      mask_q      <= mask_d;
      aspm_q      <= aspm_d;
      ls_q        <= ls_d;
      idle_q      <= idle_d;
      reg_rdata   <= rdata_d;
      turnoff_msg <= msg_d;
      pwr_en      <= pwr_d;
      dev_rst_n   <= rst_d;
      irq         <= irq_d;
    end
  end
  assign aspm_en    = aspm_q;
  assign link_state = ls_q;

  // power and reset ordering toward the device
  a_power_before_reset: assert property (@(posedge sys_clk)
    disable iff (!reset_n) $rose(dev_rst_n) |-> pwr_en)
    else $error("device reset released without power");

  a_off_needs_l23: assert property (@(posedge sys_clk)
    disable iff (!reset_n) $fell(pwr_en) |-> $past(st_q) == DPL23_ST_L23)
    else $error("power cut outside L2/L3");

  a_msg_until_ack: assert property (@(posedge sys_clk)
    disable iff (!reset_n) ack_ev |=> !turnoff_msg)
    else $error("turn-off message held after ack");

  a_off_holds_reset: assert property (@(posedge sys_clk)
    disable iff (!reset_n) !pwr_en |-> !dev_rst_n)
    else $error("device out of reset while unpowered");

  a_reset_in_reset: assert property (@(posedge sys_clk)
    !reset_n |=> !turnoff_msg && pwr_en && !dev_rst_n)
    else $error("outputs not in reset state");

  a_status_shows: assert property (@(posedge sys_clk)
    disable iff (!reset_n) reg_rd && reg_addr == ADDR_PWR_CTRL && !pwr_en
    |=> reg_rdata[BIT_PWR_IS_OFF])
    else $error("power off not reported");

  a_irq_level: assert property (@(posedge sys_clk)
    disable iff (!reset_n) ack_ev && mask_q[IRQ_ACK] |=> irq)
    else $error("acknowledge interrupt missing");

  a_l23_state: assert property (@(posedge sys_clk)
    disable iff (!reset_n) st_q == DPL23_ST_L23 |-> ##1
    link_state == DPL23_LS_L23R || st_q != DPL23_ST_L23)
    else $error("link state not L2/L3 ready");

  a_msg_only_waitack: assert property (@(posedge sys_clk)
    disable iff (!reset_n) turnoff_msg |-> st_q == DPL23_ST_WAITACK)
    else $error("turn-off message outside its wait");

  a_enter_starts_msg: assert property (@(posedge sys_clk)
    disable iff (!reset_n) st_q == DPL23_ST_ON && wr_ctrl &&
    reg_wdata[BIT_ENTER_REQ] |=> turnoff_msg)
    else $error("enter request sent no turn-off message");

  a_ack_to_l23: assert property (@(posedge sys_clk)
    disable iff (!reset_n) ack_ev |=> st_q == DPL23_ST_L23)
    else $error("acknowledge did not reach L2/L3");

  a_off_cmd_cuts: assert property (@(posedge sys_clk)
    disable iff (!reset_n) st_q == DPL23_ST_L23 && wr_ctrl &&
    reg_wdata[BIT_PWR_OFF] && cnt_q >= CNT_W'(IDLE_CYC)
    |=> !pwr_en)
    else $error("power-off command ignored");

  a_no_early_cut: assert property (@(posedge sys_clk)
    disable iff (!reset_n) st_q == DPL23_ST_L23 &&
    cnt_q < CNT_W'(IDLE_CYC) |=> pwr_en)
    else $error("power cut before link settled idle");

  a_recover_powers: assert property (@(posedge sys_clk)
    disable iff (!reset_n) st_q == DPL23_ST_OFF && wr_ctrl &&
    reg_wdata[BIT_RECOVER] |=> pwr_en && !dev_rst_n)
    else $error("recovery did not restore power under reset");

  a_pwrup_in_reset: assert property (@(posedge sys_clk)
    disable iff (!reset_n) st_q == DPL23_ST_PWRUP |-> !dev_rst_n)
    else $error("device reset released during power-up");

  a_reset_low_in_reset: assert property (@(posedge sys_clk)
    disable iff (!reset_n) st_q == DPL23_ST_RESET |-> !dev_rst_n && pwr_en)
    else $error("device reset phase wrong");

  a_release_ends_seq: assert property (@(posedge sys_clk)
    disable iff (!reset_n) $rose(dev_rst_n) |-> st_q == DPL23_ST_ON)
    else $error("device reset released mid sequence");

  // link state reporting
  a_unpowered_link: assert property (@(posedge sys_clk)
    disable iff (!reset_n) !pwr_en |-> link_state == DPL23_LS_L3)
    else $error("unpowered link not shown as L3");

  a_seq_link_l3: assert property (@(posedge sys_clk)
    disable iff (!reset_n) st_q == DPL23_ST_PWRUP ||
    st_q == DPL23_ST_RESET |-> link_state == DPL23_LS_L3)
    else $error("link not L3 while power returns");

  a_aspm_follows: assert property (@(posedge sys_clk)
    disable iff (!reset_n) reg_wr && reg_addr == ADDR_LINK_PM
    |=> aspm_en == $past(reg_wdata[0]))
    else $error("link power enable not written");

  // status, mask and read port
  a_stat_read_clears: assert property (@(posedge sys_clk)
    disable iff (!reset_n) reg_rd && reg_addr == ADDR_IRQ_STAT &&
    ev == '0 |=> stat_q == '0)
    else $error("status not cleared by read");

  a_stat_sticky: assert property (@(posedge sys_clk)
    disable iff (!reset_n) ev[IRQ_OFF] |=> stat_q[IRQ_OFF])
    else $error("power-off event not recorded");

  a_mask_write: assert property (@(posedge sys_clk)
    disable iff (!reset_n) reg_wr && reg_addr == ADDR_IRQ_MASK
    |=> mask_q == $past(reg_wdata[IRQ_W-1:0]))
    else $error("mask not written");

  a_rdata_one_cycle: assert property (@(posedge sys_clk)
    disable iff (!reset_n) !$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its cycle");

  a_irq_follows: assert property (@(posedge sys_clk)
    disable iff (!reset_n) irq == |(stat_q & mask_q))
    else $error("interrupt level disagrees with status");

  a_busy_shown: assert property (@(posedge sys_clk)
    disable iff (!reset_n) reg_rd && reg_addr == ADDR_PWR_CTRL &&
    st_q == DPL23_ST_WAITACK |=> reg_rdata[BIT_BUSY])
    else $error("busy not reported");

  a_l23_shown: assert property (@(posedge sys_clk)
    disable iff (!reset_n) reg_rd && reg_addr == ADDR_PWR_CTRL &&
    st_q == DPL23_ST_L23 |=> reg_rdata[BIT_IS_L23])
    else $error("L2/L3 not reported");

  // idle only moves once the last two stages agree
  a_idle_sync: assert property (@(posedge sys_clk)
    disable iff (!reset_n) $changed(idle_q)
    |-> $past(idle_sync_q[1]) == $past(idle_sync_q[2]))
    else $error("idle taken before synchroniser agreed");

  c_ack: cover property (@(posedge sys_clk) disable iff (!reset_n) ack_ev);
  c_off: cover property (@(posedge sys_clk) disable iff (!reset_n)
    $fell(pwr_en));
  c_recover: cover property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(dev_rst_n) ##1 irq);
  c_refused_off: cover property (@(posedge sys_clk) disable iff (!reset_n)
    st_q == DPL23_ST_ON && wr_ctrl && reg_wdata[BIT_PWR_OFF]);
  c_aspm_low: cover property (@(posedge sys_clk) disable iff (!reset_n)
    link_state == DPL23_LS_L0S);
endmodule : dpl23_power_ctrl
`default_nettype wire

// File: bench/dpl23_dev_model.sv
// dpl23_dev_model: downstream device and its power module, as seen
// assumes the sequencer's sys_clk; answers a turn-off DLY+1 cycles after it appears
`default_nettype none
module dpl23_dev_model #(
  parameter int DLY = 3
) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic turnoff_msg,
  input  wire logic pwr_en,
  output logic      turnoff_ack,
  output logic      link_idle
);
  timeunit 1ns;
  timeprecision 1ns;
  int   cnt;
  logic pwr_q;
  always @(posedge sys_clk) begin
    turnoff_ack <= 1'b0;
    pwr_q       <= pwr_en;
    if (!reset_n) begin
      cnt       <= 0;
      link_idle <= 1'b0;
    end else if (turnoff_msg && cnt < DLY) begin
      cnt <= cnt + 1;
    end else if (turnoff_msg) begin
      // answer and drop the link into L2/L3 on the same edge
      turnoff_ack <= 1'b1;
      link_idle   <= 1'b1;
      cnt         <= 0;
    end else begin
      cnt <= 0;
      // power back: link leaves electrical idle to retrain
      if (pwr_en && !pwr_q)
        link_idle <= 1'b0;
    end
  end
endmodule : dpl23_dev_model
`default_nettype wire

// File: bench/test_downstream_port_l2l3_power_control.sv
// test_downstream_port_l2l3_power_control: register driven sequence test
// assumes short counts: settle 4, device reset 4, idle 2 cycles
`default_nettype none
module test_downstream_port_l2l3_power_control;
  import dpl23_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, reset_n, reg_wr, reg_rd, irq, aspm_en;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic        turnoff_msg, turnoff_ack, link_idle, pwr_en, dev_rst_n;
  logic [2:0]  link_state;
  int          err_total, total_checks;

  dpl23_power_ctrl #(.SETTLE_CYC(4), .RESET_CYC(4), .IDLE_CYC(2))
    u_dpl23_power_ctrl (.sys_clk, .reset_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .turnoff_msg, .turnoff_ack,
    .link_idle, .pwr_en, .dev_rst_n, .aspm_en, .link_state, .irq);
  dpl23_dev_model u_dpl23_dev_model (.sys_clk, .reset_n, .turnoff_msg,
    .pwr_en, .turnoff_ack, .link_idle);

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge sys_clk);
  endtask : rd

  task automatic wait_irq;
    for (int i = 0; i < 100 && irq !== 1'b1; i++) @(posedge sys_clk);
    if (irq !== 1'b1) begin
      err_total++;
      close_out();
    end
  endtask : wait_irq

  initial begin
    {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (5) @(posedge sys_clk);
    #1 check(dev_rst_n, 1'b0);
    check(turnoff_msg, 1'b0);
    @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 check(dev_rst_n, 1'b1);
    check(pwr_en, 1'b1);
    @(posedge sys_clk);
    rd(ADDR_IRQ_MASK, d); check(d, 32'h0);
    rd(12'h0B0, d); check(d, 32'h0);
    wr(ADDR_LINK_PM, 32'h1);
    #1 check(aspm_en, 1'b1);
    check(link_state, DPL23_LS_L0S);
    wr(ADDR_PWR_CTRL, 32'h2);
    #1 check(pwr_en, 1'b1);
    wr(ADDR_IRQ_MASK, 32'h7);
    wr(ADDR_PWR_CTRL, 32'h1);
    #1 check(turnoff_msg, 1'b1);
    wait_irq();
    rd(ADDR_IRQ_STAT, d); check(d, 32'h1);
    #1 check(irq, 1'b0);
    check(link_state, DPL23_LS_L23R);
    check(turnoff_msg, 1'b0);
    repeat (6) @(posedge sys_clk);
    rd(ADDR_PWR_CTRL, d); check(d & 32'h300, 32'h100);
    wr(ADDR_PWR_CTRL, 32'h2);
    #1 check(pwr_en, 1'b0);
    check(dev_rst_n, 1'b0);
    check(link_state, DPL23_LS_L3);
    wait_irq();
    rd(ADDR_IRQ_STAT, d); check(d, 32'h2);
    rd(ADDR_PWR_CTRL, d); check(d & 32'h300, 32'h300);
    wr(ADDR_IRQ_MASK, 32'h3);
    wr(ADDR_PWR_CTRL, 32'h4);
    #1 check(pwr_en, 1'b1);
    check(dev_rst_n, 1'b0);
    rd(ADDR_PWR_CTRL, d); check(d & 32'hF00, 32'hC00);
    repeat (5) @(posedge sys_clk);
    #1 check(dev_rst_n, 1'b0);
    repeat (15) @(posedge sys_clk);
    #1 check(dev_rst_n, 1'b1);
    check(irq, 1'b0);
    rd(ADDR_IRQ_STAT, d); check(d, 32'h4);
    check(link_state, DPL23_LS_L0S);
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 check(dev_rst_n, 1'b0);
    check(aspm_en, 1'b0);
    check(link_state, DPL23_LS_L0);
    @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 check(dev_rst_n, 1'b1);
    check(pwr_en, 1'b1);
    close_out();
  end
endmodule : test_downstream_port_l2l3_power_control
`default_nettype wire
